// >>> core/edpm_top.v
// Energy-detect power-management controller with an APB3 register slave.
// Assumes line energy and wake events arrive synchronous to pclk, and
// presetn is the power-up reset.
`timescale 1ns/1ps
`default_nettype none
`include "edpm_consts.vh"

module edpm_top #(
  parameter [`EDPM_CYC_W-1:0] WAKE_UNIT_CYC = `EDPM_WAKE_UNIT_CYC,
  parameter [`EDPM_CYC_W-1:0] SLEEP_UNIT_CYC = `EDPM_SLEEP_UNIT_CYC
) (
  // Clock and power-up reset
  input wire pclk,
  input wire presetn,
  // APB3 slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Device resets that spare the wake event bits
  input wire dev_reset,
  // Line and wake events
  input wire energy_detect,
  input wire link_up_event,
  input wire magic_event,
  input wire wake_frame_event,
  // Power state outputs
  output reg power_event_out,
  output reg low_power_state,
  output reg packet_enable,
  output reg soft_power_down,
  output reg power_saving,
  output reg [1:0] power_mode
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg dly_en_r;
  reg rsv13_r;
  reg pol_r;
  reg [3:0] ev_en_r;
  reg auto_en_r;
  reg to_norm_r;
  reg [1:0] mode_r;
  reg [7:0] wake_time_r;
  reg [7:0] sleep_time_r;
  reg ist_energy_r;
  reg ist_link_r;
  reg low_r;
  reg grst_cnt_r;

  wire [3:0] ev_q;
  wire [3:0] ev_set;
  wire [3:0] ev_clr;
  wire wake_done;
  wire sleep_done;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // One wait state: pready rises on the second access cycle
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire [`EDPM_IDX_W-1:0] idx = paddr[11:2];
  wire hit_pec = (idx == `EDPM_PEC_IDX);
  wire hit_swt = (idx == `EDPM_SWT_IDX);
  wire hit_grst = (idx == `EDPM_GRST_IDX);
  wire hit_ist = (idx == `EDPM_IST_IDX);
  wire hit_any = hit_pec | hit_swt | hit_grst | hit_ist;
  wire wr_pec = wr & hit_pec;
  wire wr_swt = wr & hit_swt;
  wire wr_ist = wr & hit_ist;
  wire rd_grst = rd & hit_grst;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire ed_mode = (mode_r == `EDPM_MODE_ENERGY);
  wire spd_mode = (mode_r == `EDPM_MODE_SPD);
  // Host wake counts reads only while asleep
  wire asleep = (ed_mode & low_r) | spd_mode;

  wire host_wake = rd_grst & grst_cnt_r & asleep;

  wire energy_wake = ed_mode & low_r & auto_en_r & wake_done;

  // ----------------------------------------
  // Line timers
  // ----------------------------------------
  // run drops on change
  wire wake_run = ed_mode & low_r & energy_detect;
  wire sleep_run = ed_mode & ~low_r & ~energy_detect;

  edpm_timer #(
    .UNIT_CYC(WAKE_UNIT_CYC)
  ) u_wake_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(wake_run),
    .limit(wake_time_r),
    .done_r(wake_done)
  );

  edpm_timer #(
    .UNIT_CYC(SLEEP_UNIT_CYC)
  ) u_sleep_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(sleep_run),
    .limit(sleep_time_r),
    .done_r(sleep_done)
  );

  // ----------------------------------------
  // Wake event bits
  // ----------------------------------------
  // one set line per event source; several can fire in one cycle
  assign ev_set[`EDPM_EV_ENERGY] = energy_wake;
  assign ev_set[`EDPM_EV_LINK] = link_up_event;
  assign ev_set[`EDPM_EV_MAGIC] = magic_event;
  assign ev_set[`EDPM_EV_FRAME] = wake_frame_event;
  assign ev_clr = wr_pec ? pwdata[`EDPM_PEC_EVT_HI:`EDPM_PEC_EVT_LO] : 4'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `EDPM_NUM_EV; gi = gi + 1) begin : g_ev
      edpm_evbit u_evbit (
        .pclk(pclk),
        .presetn(presetn),
        .set(ev_set[gi]),
        .clr(ev_clr[gi]),
        .q_r(ev_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_en_r <= 1'b0;
      rsv13_r <= 1'b0;
      pol_r <= 1'b0;
      ev_en_r <= 4'h0;
      auto_en_r <= 1'b0;
      to_norm_r <= 1'b0;
      mode_r <= `EDPM_MODE_NORMAL;
      wake_time_r <= `EDPM_WAKE_RST;
      sleep_time_r <= `EDPM_SLEEP_RST;
    end else if (dev_reset) begin
      dly_en_r <= 1'b0;
      rsv13_r <= 1'b0;
      pol_r <= 1'b0;
      ev_en_r <= 4'h0;
      auto_en_r <= 1'b0;
      to_norm_r <= 1'b0;
      mode_r <= `EDPM_MODE_NORMAL;
      wake_time_r <= `EDPM_WAKE_RST;
      sleep_time_r <= `EDPM_SLEEP_RST;
    end else begin
      if (wr_pec) begin
        dly_en_r <= pwdata[`EDPM_PEC_DLY];
        rsv13_r <= pwdata[`EDPM_PEC_RSV13];
        pol_r <= pwdata[`EDPM_PEC_POL];
        ev_en_r <= pwdata[`EDPM_PEC_EN_HI:`EDPM_PEC_EN_LO];
        auto_en_r <= pwdata[`EDPM_PEC_AUTO];
        to_norm_r <= pwdata[`EDPM_PEC_TONORM];
        mode_r <= pwdata[`EDPM_PEC_MODE_HI:`EDPM_PEC_MODE_LO];
      end else if (host_wake) begin
        mode_r <= `EDPM_MODE_NORMAL;
      end else if (energy_wake & to_norm_r) begin
        mode_r <= `EDPM_MODE_NORMAL;
      end
      // zero is software's fault, not trapped here
      if (wr_swt) begin
        wake_time_r <= pwdata[`EDPM_SWT_WAKE_HI:`EDPM_SWT_WAKE_LO];
        sleep_time_r <= pwdata[`EDPM_SWT_SLEEP_HI:`EDPM_SWT_SLEEP_LO];
      end
    end
  end

  // ----------------------------------------
  // Low-power state and host wake counter
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= 1'b0;
      grst_cnt_r <= 1'b0;
    end else if (dev_reset) begin
      low_r <= 1'b0;
      grst_cnt_r <= 1'b0;
    end else begin
      if (!ed_mode | energy_wake | host_wake) begin
        low_r <= 1'b0;
      end else if (sleep_done) begin
        low_r <= 1'b1;
      end
      // Stray reads while awake never count toward a later wake
      if (!asleep | host_wake) begin
        grst_cnt_r <= 1'b0;
      end else if (rd_grst) begin
        grst_cnt_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status bits
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_energy_r <= 1'b0;
      ist_link_r <= 1'b0;
    end else begin
      ist_energy_r <= ev_set[`EDPM_EV_ENERGY] |
        (ist_energy_r & ~(wr_ist & pwdata[`EDPM_IST_ENERGY]));
      ist_link_r <= ev_set[`EDPM_EV_LINK] |
        (ist_link_r & ~(wr_ist & pwdata[`EDPM_IST_LINK]));
    end
  end

  // ----------------------------------------
  // Read mux and bus answer
  // ----------------------------------------
  reg [15:0] rd_word;
  always @* begin
    rd_word = 16'h0000;
    if (hit_pec) begin
      rd_word = {1'b0, dly_en_r, rsv13_r, pol_r, ev_en_r, auto_en_r, to_norm_r, ev_q, mode_r};
    end else if (hit_swt) begin
      rd_word = {wake_time_r, sleep_time_r};
    end else if (hit_ist) begin
      rd_word[`EDPM_IST_ENERGY] = ist_energy_r;
      rd_word[`EDPM_IST_LINK] = ist_link_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : {16'h0000, rd_word};
        pslverr <= ~hit_any;
      end else begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  // enabled events; drops with them
  wire pevt_active = |(ev_q & ev_en_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_event_out <= 1'b1;
      low_power_state <= 1'b0;
      packet_enable <= 1'b0;
      soft_power_down <= 1'b0;
      power_saving <= 1'b0;
      power_mode <= `EDPM_MODE_NORMAL;
    end else begin
      power_event_out <= pol_r ? pevt_active : ~pevt_active;
      low_power_state <= ed_mode & low_r;
      packet_enable <= ~(ed_mode & low_r);
      soft_power_down <= spd_mode;
      power_saving <= (mode_r == `EDPM_MODE_SAVE);
      power_mode <= mode_r;
    end
  end

endmodule // edpm_top
`default_nettype wire

// >>> core/edpm_consts.vh
// Constants for the energy-detect power-management block.
// Included by every design file of the block but the event bit; holds definitions only.
`ifndef EDPM_CONSTS_VH
`define EDPM_CONSTS_VH

// ----------------------------------------
// Clock and time units
// ----------------------------------------
`define EDPM_CLK_NS 4
`define EDPM_WAKE_UNIT_NS 16000000
`define EDPM_SLEEP_UNIT_NS 1000000000
// Cycles per unit at the 4 ns clock, sized to the cycle counter
`define EDPM_WAKE_UNIT_CYC 28'h03D0900
`define EDPM_SLEEP_UNIT_CYC 28'hEE6B280
`define EDPM_CYC_W 28
`define EDPM_UNITS_W 8

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define EDPM_IDX_W 10
`define EDPM_PEC_IDX 10'h0D4
`define EDPM_SWT_IDX 10'h0D6
`define EDPM_GRST_IDX 10'h004
`define EDPM_IST_IDX 10'h005

// ----------------------------------------
// power_event_control fields
// ----------------------------------------
`define EDPM_PEC_DLY 14
`define EDPM_PEC_RSV13 13
`define EDPM_PEC_POL 12
`define EDPM_PEC_EN_HI 11
`define EDPM_PEC_EN_LO 8
`define EDPM_PEC_AUTO 7
`define EDPM_PEC_TONORM 6
`define EDPM_PEC_EVT_HI 5
`define EDPM_PEC_EVT_LO 2
`define EDPM_PEC_MODE_HI 1
`define EDPM_PEC_MODE_LO 0

// ----------------------------------------
// Wake event positions within the event field
// ----------------------------------------
`define EDPM_EV_ENERGY 0
`define EDPM_EV_LINK 1
`define EDPM_EV_MAGIC 2
`define EDPM_EV_FRAME 3
`define EDPM_NUM_EV 4

// ----------------------------------------
// Power modes
// ----------------------------------------
`define EDPM_MODE_NORMAL 2'h0
`define EDPM_MODE_ENERGY 2'h1
`define EDPM_MODE_SPD 2'h2
`define EDPM_MODE_SAVE 2'h3

// ----------------------------------------
// sleep_wake_timing fields and resets
// ----------------------------------------
`define EDPM_SWT_WAKE_HI 15
`define EDPM_SWT_WAKE_LO 8
`define EDPM_SWT_SLEEP_HI 7
`define EDPM_SWT_SLEEP_LO 0
`define EDPM_WAKE_RST 8'h08
`define EDPM_SLEEP_RST 8'h0C

// ----------------------------------------
// interrupt_status_register bits
// ----------------------------------------
`define EDPM_IST_ENERGY 2
`define EDPM_IST_LINK 3

`endif

// >>> core/edpm_timer.v
// Continuous-condition timer: counts whole time units while run is held.
// Assumes run drops whenever the watched line condition breaks.
`timescale 1ns/1ps
`default_nettype none
`include "edpm_consts.vh"

module edpm_timer #(
  parameter [`EDPM_CYC_W-1:0] UNIT_CYC = 28'h0000010
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire run,
  input wire [`EDPM_UNITS_W-1:0] limit,
  // Status
  output reg done_r
);

  localparam [`EDPM_CYC_W-1:0] LAST_CYC = UNIT_CYC - 28'h0000001;

  reg [`EDPM_CYC_W-1:0] cyc_r;
  reg [`EDPM_UNITS_W-1:0] units_r;

  // ----------------------------------------
  // Prescaler and unit counter
  // ----------------------------------------
  // Prescaler restarts with run, so a limit of N is never shorter than N units
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 28'h0000000;
      units_r <= 8'h00;
      done_r <= 1'b0;
    end else if (!run) begin
      cyc_r <= 28'h0000000;
      units_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      if (cyc_r == LAST_CYC) begin
        cyc_r <= 28'h0000000;
        // Saturate rather than wrap
        if (units_r != 8'hFF) begin
          units_r <= units_r + 8'h01;
        end
      end else begin
        cyc_r <= cyc_r + 28'h0000001;
      end
      done_r <= (units_r >= limit);
    end
  end

endmodule // edpm_timer
`default_nettype wire

// >>> core/edpm_evbit.v
// One sticky wake event bit: set by hardware, cleared by writing one.
// Only power-up reset clears it; device resets leave it alone.
`timescale 1ns/1ps
`default_nettype none

module edpm_evbit (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire set,
  input wire clr,
  // Status
  output reg q_r
);

  // ----------------------------------------
  // Sticky flag
  // ----------------------------------------
  // Set beats clear so a same-cycle event is not lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= 1'b0;
    end else begin
      q_r <= set | (q_r & ~clr);
    end
  end

endmodule // edpm_evbit
`default_nettype wire

// >>> bench/edpm_checker.sv
// Checker for the power-management block: APB answer timing and mode rules.
// Bound to edpm_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "edpm_consts.vh"

module edpm_checker #(
  parameter [`EDPM_CYC_W-1:0] WAKE_UNIT_CYC = `EDPM_WAKE_UNIT_CYC,
  parameter [`EDPM_CYC_W-1:0] SLEEP_UNIT_CYC = `EDPM_SLEEP_UNIT_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // Line and power state
  input wire dev_reset,
  input wire energy_detect,
  input wire low_power_state,
  input wire packet_enable,
  input wire soft_power_down,
  input wire power_saving,
  input wire [1:0] power_mode
);
  logic [`EDPM_CYC_W-1:0] quiet_r;
  logic [`EDPM_CYC_W-1:0] en_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Saturating runs of silence and of energy, wide enough for a full unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_r <= 28'h0000000;
      en_r <= 28'h0000000;
    end else begin
      quiet_r <= energy_detect ? 28'h0000000 : quiet_r + {27'h0000000, ~&quiet_r};
      en_r <= energy_detect ? en_r + {27'h0000000, ~&en_r} : 28'h0000000;
    end
  end

  AST_READY_PULSE: assert property (pready |=> !pready) // one-cycle answer
    else $error("pready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) // refusal rides the answer
    else $error("pslverr without pready");
  AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready) // one wait state
    else $error("answer not in second access cycle");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000) // idle read data
    else $error("read data outside answer");
  AST_PKT_FLOW: assert property ($past(presetn) |-> packet_enable != low_power_state)
    else $error("packet enable disagrees with low-power state");
  AST_MODE_FLAGS: assert property (
    soft_power_down == (power_mode == `EDPM_MODE_SPD) &&
    power_saving == (power_mode == `EDPM_MODE_SAVE))
    else $error("mode flags disagree with mode");
  // Cause lies two edges back: state register, then output register
  AST_SPD_HOST_ONLY: assert property ($fell(soft_power_down) |->
    $past(pready) || $past(pready, 2) || $past(dev_reset, 2))
    else $error("soft power down left without host access");
  AST_SLEEP_AFTER_QUIET: assert property ($rose(low_power_state) |->
    quiet_r >= SLEEP_UNIT_CYC && $past(power_mode) == `EDPM_MODE_ENERGY)
    else $error("low power entered too early");
  AST_WAKE_CAUSE: assert property ($fell(low_power_state) |->
    en_r >= WAKE_UNIT_CYC || $past(pready) || $past(pready, 2) || $past(dev_reset, 2))
    else $error("low power left without cause");
endmodule // edpm_checker

bind edpm_top edpm_checker #(.WAKE_UNIT_CYC(WAKE_UNIT_CYC), .SLEEP_UNIT_CYC(SLEEP_UNIT_CYC))
  edpm_checker_inst (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
  .dev_reset, .energy_detect, .low_power_state, .packet_enable, .soft_power_down,
  .power_saving, .power_mode);
`default_nettype wire

// >>> bench/edpm_host.sv
// Host model: APB master issuing single transfers and the host wake reads.
// Assumes the caller enters a task at or after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module edpm_host (
  // Clock and answer
  input wire logic pclk,
  input wire logic pready,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // Request held until pready is seen high; only the bench timeout ends a wait
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wake;
    xfer(1'b0, 12'h010, 32'h00000000);
    xfer(1'b0, 12'h010, 32'h00000000);
  endtask
endmodule // edpm_host
`default_nettype wire

// >>> bench/tb_top.sv
// Testbench: drives resets, line energy and wake events; host model talks APB.
// Answers are checked against a queue of notes by a monitor process.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [11:0] A_PEC = 12'h350;
  localparam logic [11:0] A_SWT = 12'h358;
  localparam logic [11:0] A_IST = 12'h014;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic dev_reset = 1'b0;
  logic energy_detect = 1'b0;
  logic [2:0] ev = 3'h0;
  logic psel, penable, pwrite, pready, pslverr, pevt, lps, pkt, spd, psave;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] pmode;
  logic [33:0] expq[$];
  int fails = 0;
  int checks = 0;

  always #2 pclk = ~pclk;

  edpm_host edpm_host_inst (.pclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
  edpm_top #(.WAKE_UNIT_CYC(28'h0000004), .SLEEP_UNIT_CYC(28'h0000008)) edpm_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dev_reset, .energy_detect, .link_up_event(ev[0]), .magic_event(ev[1]),
    .wake_frame_event(ev[2]), .power_event_out(pevt), .low_power_state(lps),
    .packet_enable(pkt), .soft_power_down(spd), .power_saving(psave), .power_mode(pmode));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic er = 1'b0);
    expq.push_back({1'b0, er, 32'h00000000});
    edpm_host_inst.xfer(1'b1, a, {16'h0000, d});
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic er = 1'b0);
    expq.push_back({1'b1, er, 16'h0000, d});
    edpm_host_inst.xfer(1'b0, a, 32'h00000000);
  endtask

  task automatic hw;
    expq.push_back(34'h200000000);
    expq.push_back(34'h200000000);
    edpm_host_inst.wake();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wlp(input logic v);
    int n;
    n = 0;
    while (lps !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, lps}, {31'h0, v});
  endtask

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----
  // Answer monitor
  // ----
  always @(posedge pclk) begin
    logic [33:0] e;
    if (pready === 1'b1) begin
      if (expq.size() == 0) begin
        fails++;
        $display("wrong value at %0t: answer without request", $time);
      end else begin
        e = expq.pop_front();
        chk({31'h0, pslverr}, {31'h0, e[32]});
        if (e[33])
          chk(prdata, e[31:0]);
      end
    end
  end

  initial begin
    #20000;
    fails++;
    final_report();
  end

  initial begin
    logic [31:0] v;
    logic [15:0] x;
    v = $urandom(68280);
    cyc(2);
    presetn <= 1'b1;
    chk({31'h0, pevt}, 32'h1);
    rd(A_PEC, 16'h0000);
    rd(A_SWT, 16'h080C);
    rd(12'h354, 16'h0000, 1'b1);
    wr(12'h354, 16'hFFFF, 1'b1);
    wr(A_SWT, 16'h0102);
    wr(A_PEC, 16'h11C1);
    rd(A_PEC, 16'h11C1);
    wlp(1'b1);
    chk({31'h0, pkt}, 32'h0);
    energy_detect <= 1'b1;
    wlp(1'b0);
    cyc(4);
    chk({30'h0, pmode}, 32'h0);
    chk({31'h0, pevt}, 32'h1);
    rd(A_PEC, 16'h11C4);
    rd(A_IST, 16'h0004);
    dev_reset <= 1'b1;
    cyc(1);
    dev_reset <= 1'b0;
    rd(A_PEC, 16'h0004);
    wr(A_PEC, 16'h0004);
    wr(A_IST, 16'h0004);
    rd(A_PEC, 16'h0000);
    rd(A_IST, 16'h0000);
    // Energy blip must restart the silence count
    energy_detect <= 1'b0;
    wr(A_PEC, 16'h0001);
    cyc(60);
    energy_detect <= 1'b1;
    cyc(1);
    energy_detect <= 1'b0;
    cyc(60);
    chk({31'h0, lps}, 32'h0);
    wlp(1'b1);
    energy_detect <= 1'b1;
    cyc(40);
    chk({31'h0, lps}, 32'h1);
    rd(A_PEC, 16'h0001);
    // Auto wake without wake-to-normal stays in energy detect mode
    wr(A_PEC, 16'h0081);
    wlp(1'b0);
    rd(A_PEC, 16'h0085);
    rd(A_IST, 16'h0004);
    wr(A_IST, 16'h0004);
    energy_detect <= 1'b0;
    wr(A_PEC, 16'h0005);
    wlp(1'b1);
    hw();
    cyc(3);
    chk({30'h0, pmode, lps}, 32'h0);
    energy_detect <= 1'b1;
    wr(A_PEC, 16'h0082);
    cyc(40);
    chk({30'h0, pmode, spd}, 32'h5);
    hw();
    cyc(3);
    chk({30'h0, pmode, spd}, 32'h0);
    wr(A_PEC, 16'h0003);
    cyc(3);
    chk({31'h0, psave}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      x = {1'b0, v[2:0], 12'h000} | (16'h0200 << i);
      wr(A_PEC, x);
      ev[i] <= 1'b1;
      cyc(1);
      ev[i] <= 1'b0;
      cyc(3);
      chk({31'h0, pevt}, {31'h0, v[0]});
      rd(A_PEC, x | (16'h0008 << i));
      rd(A_IST, (i == 0) ? 16'h0008 : 16'h0000);
      wr(A_PEC, x | (16'h0008 << i));
      cyc(3);
      chk({31'h0, pevt}, {31'h0, ~v[0]});
      wr(A_IST, 16'h0008);
    end
    cyc(4);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
